// file: design/bftf_lowpass.sv
// First-order low-pass filter for 8-bit temperature samples.
// Assumes a one-cycle tick every 0.5 ms and samples as single-cycle strobes.
`timescale 1ns/1ps
module bftf_lowpass #(
  parameter int SHIFT = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic sample_valid,
  input wire logic [7:0] sample,
  input wire logic bypass,
  input wire logic [15:0] period,
  output logic [7:0] filtered
);

  logic [7:0] latest;
  logic primed;
  logic [15:0] tick_cnt;
  logic [15:0] acc;
  logic signed [16:0] diff;

  assign diff = $signed({1'b0, latest, 8'h00}) - $signed({1'b0, acc});

  // ----------------------------------------------------------------------
  // Latest sample
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      latest <= 8'h00;
      primed <= 1'b0;
    end else if (sample_valid) begin
      latest <= sample;
      primed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Update pacing and accumulator, 8.8 fixed point
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 16'h0000;
      acc <= 16'h0000;
    end else if (bypass || !primed) begin
      tick_cnt <= 16'h0000;
      // First sample loads straight in, not the stale latest value
      acc <= {(sample_valid ? sample : latest), 8'h00};
    end else if (tick) begin
      if (tick_cnt + 16'h0001 >= period) begin
        tick_cnt <= 16'h0000;
        acc <= acc + 16'(diff >>> SHIFT);
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filtered <= 8'h00;
    end else if (bypass) begin
      filtered <= latest;
    end else begin
      filtered <= acc[15:8];
    end
  end

endmodule

// file: design/bftf_params.svh
// Constants of the boost fault, temperature filter and calibration dim block.
// Assumes a 100 MHz clock and word-wide register access over AHB-Lite.
//
// Notes on behaviour
// - Headroom fault after low headroom persists 0,1,2,2.5,3,3.5,4,5 ms.
// - Restart bit 0: boost overvoltage fault latches, boost stays shut down.
// - Restart bit 1: restart once boost falls to the 195 V nominal level.
// - Fast filter: 000 bypass, 001-101 233 ms to 3.733 s, 110 reserved.
// - Fast-filtered temperature drives overtemperature detect and colour gain.
// - Slow filter codes select 3.75 s to 2 min.
// - Slow-filtered temperature drives dim derating above the derating set point.
// - Calibration dim register sets dim in calibration and leading-edge modes.
// - Calibration dim value zero is replaced by 0x7f, half dim.
// - Twelve-bit calibration dim equals setting times 16 plus 15.
`ifndef BFTF_PARAMS_SVH
`define BFTF_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define BFTF_IDX_FAULT_TIMING 8'h56
`define BFTF_IDX_TEMP_FILTER 8'h57
`define BFTF_IDX_CAL_DIM 8'h59
`define BFTF_IDX_CONTROL 8'h60
`define BFTF_IDX_STATUS 8'h61
`define BFTF_IDX_OUTPUT 8'h62

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define BFTF_WINDOW_LSB 5
`define BFTF_RESTART_BIT 4
`define BFTF_FAULT_TIMING_MASK 8'hf0
`define BFTF_FAST_LSB 3
`define BFTF_SLOW_LSB 0
`define BFTF_TEMP_FILTER_MASK 8'h3f
`define BFTF_CTRL_FULL_CUR_BIT 0
`define BFTF_CTRL_CAL_MODE_BIT 1
`define BFTF_CTRL_LEADING_BIT 2
`define BFTF_CTRL_DERATE_EN_BIT 3
`define BFTF_CTRL_SHUTDOWN_LSB 8
`define BFTF_CTRL_DERATE_LSB 16
`define BFTF_CTRL_MASK 32'h00ffff0f
`define BFTF_STAT_HEADROOM_BIT 0
`define BFTF_STAT_OV_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BFTF_RST_FAULT_TIMING 8'h00
`define BFTF_RST_TEMP_FILTER 8'h00
`define BFTF_RST_CAL_DIM 8'h00
`define BFTF_RST_CONTROL 32'h00000000

// ----------------------------------------------------------------------
// Calibration dim
// ----------------------------------------------------------------------
`define BFTF_CAL_DIM_ZERO_SUB 8'h7f
`define BFTF_CAL_DIM_ADD 4'hf

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BFTF_CLK_PERIOD_NS 10
`define BFTF_TICK_US 500
`define BFTF_FILT_SHIFT 4
`define BFTF_FAST_TAU_1_US 233000
`define BFTF_FAST_TAU_2_US 466000
`define BFTF_FAST_TAU_3_US 933000
`define BFTF_FAST_TAU_4_US 1866000
`define BFTF_FAST_TAU_5_US 3733000
`define BFTF_SLOW_TAU_0_US 3750000
`define BFTF_SLOW_TAU_1_US 7500000
`define BFTF_SLOW_TAU_2_US 10000000
`define BFTF_SLOW_TAU_3_US 15000000
`define BFTF_SLOW_TAU_4_US 20000000
`define BFTF_SLOW_TAU_5_US 30000000
`define BFTF_SLOW_TAU_6_US 60000000
`define BFTF_SLOW_TAU_7_US 120000000

`endif

// file: design/bftf_pkg.sv
// Types of the boost fault, temperature filter and calibration dim block.
// Assumes the constants header is compiled alongside.
package bftf_pkg;

  typedef enum logic [1:0] {
    BFTF_RUN,
    BFTF_OV_LATCHED,
    BFTF_OV_RECOVER
  } bftf_ov_state_t;

  typedef struct packed {
    logic [7:0] idx;
    logic write;
    logic valid;
  } bftf_bus_req_t;

  typedef struct packed {
    logic [7:0] derate_point;
    logic [7:0] shutdown_point;
    logic derate_en;
    logic leading_edge;
    logic cal_mode;
    logic full_current;
  } bftf_ctrl_t;

endpackage

// file: design/bftf_top.sv
// Boost fault timing, temperature filters and calibration dim, AHB-Lite slave.
// Assumes comparator and sample inputs synchronous to CLK, one bus master.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "bftf_params.svh"
module bftf_top #(
  parameter int HALF_MS_CYCLES = (`BFTF_TICK_US * 1000) / `BFTF_CLK_PERIOD_NS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic HEADROOM_LOW,
  input wire logic OV_DETECT,
  input wire logic BST_AT_NOMINAL,
  input wire logic TEMP_VALID,
  input wire logic [7:0] TEMP_SAMPLE,
  input wire logic [11:0] DIM_REQ,
  output logic BOOST_SHUTDOWN,
  output logic HEADROOM_FAULT,
  output logic EXT_OVERTEMP,
  output logic [7:0] COLOR_TEMP,
  output logic DERATE_ACTIVE,
  output logic [11:0] DIM_LEVEL,
  output logic FULL_CURRENT
);

  bftf_pkg::bftf_bus_req_t req;
  bftf_pkg::bftf_ctrl_t ctrl;
  bftf_pkg::bftf_ctrl_t next_ctrl;
  bftf_pkg::bftf_ov_state_t ov_state;
  logic [7:0] fault_timing;
  logic [7:0] temp_filter;
  logic [7:0] cal_dim;
  logic [7:0] next_fault_timing;
  logic [7:0] next_temp_filter;
  logic [7:0] next_cal_dim;
  logic [31:0] read_word;
  logic wr_now;
  logic take;
  logic [7:0] take_idx;
  logic [19:0] half_ms_cnt;
  logic tick;
  logic [19:0] headroom_cnt;
  logic [19:0] headroom_limit;
  logic [2:0] fast_sel;
  logic [2:0] slow_sel;
  logic [7:0] fast_temp;
  logic [7:0] slow_temp;
  logic [15:0] fast_period;
  logic [15:0] slow_period;
  logic fast_bypass;
  logic [11:0] cal_dim_level;
  logic [11:0] derated_dim;
  logic [11:0] derate_amount;
  logic [7:0] cal_dim_used;

  // ----------------------------------------------------------------------
  // Tick counts from times
  // ----------------------------------------------------------------------
  function automatic logic [15:0] tau_to_period(input int tau_us);
    int per;
    per = (tau_us + ((`BFTF_TICK_US << `BFTF_FILT_SHIFT) / 2)) /
      (`BFTF_TICK_US << `BFTF_FILT_SHIFT);
    if (per < 1) begin
      per = 1;
    end
    return per[15:0];
  endfunction

  function automatic logic [15:0] fast_table(input logic [2:0] code);
    unique case (code)
      3'h1: fast_table = tau_to_period(`BFTF_FAST_TAU_1_US);
      3'h2: fast_table = tau_to_period(`BFTF_FAST_TAU_2_US);
      3'h3: fast_table = tau_to_period(`BFTF_FAST_TAU_3_US);
      3'h4: fast_table = tau_to_period(`BFTF_FAST_TAU_4_US);
      3'h5: fast_table = tau_to_period(`BFTF_FAST_TAU_5_US);
      default: fast_table = 16'h0001;
    endcase
  endfunction

  function automatic logic [15:0] slow_table(input logic [2:0] code);
    unique case (code)
      3'h0: slow_table = tau_to_period(`BFTF_SLOW_TAU_0_US);
      3'h1: slow_table = tau_to_period(`BFTF_SLOW_TAU_1_US);
      3'h2: slow_table = tau_to_period(`BFTF_SLOW_TAU_2_US);
      3'h3: slow_table = tau_to_period(`BFTF_SLOW_TAU_3_US);
      3'h4: slow_table = tau_to_period(`BFTF_SLOW_TAU_4_US);
      3'h5: slow_table = tau_to_period(`BFTF_SLOW_TAU_5_US);
      3'h6: slow_table = tau_to_period(`BFTF_SLOW_TAU_6_US);
      3'h7: slow_table = tau_to_period(`BFTF_SLOW_TAU_7_US);
    endcase
  endfunction

  // Window in half milliseconds: 0, 1, 2, 2.5, 3, 3.5, 4, 5 ms
  function automatic logic [3:0] window_halves(input logic [2:0] code);
    unique case (code)
      3'h0: window_halves = 4'h0;
      3'h1: window_halves = 4'h2;
      3'h2: window_halves = 4'h4;
      3'h3: window_halves = 4'h5;
      3'h4: window_halves = 4'h6;
      3'h5: window_halves = 4'h7;
      3'h6: window_halves = 4'h8;
      3'h7: window_halves = 4'ha;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  assign take = HSEL && HTRANS[1] && HREADY;
  assign take_idx = HADDR[9:2];
  assign wr_now = req.valid && req.write;

  always_comb begin
    next_fault_timing = fault_timing;
    next_temp_filter = temp_filter;
    next_cal_dim = cal_dim;
    next_ctrl = ctrl;
    if (wr_now) begin
      unique case (req.idx)
        `BFTF_IDX_FAULT_TIMING: next_fault_timing = HWDATA[7:0] & `BFTF_FAULT_TIMING_MASK;
        `BFTF_IDX_TEMP_FILTER: next_temp_filter = HWDATA[7:0] & `BFTF_TEMP_FILTER_MASK;
        `BFTF_IDX_CAL_DIM: next_cal_dim = HWDATA[7:0];
        `BFTF_IDX_CONTROL: next_ctrl = bftf_pkg::bftf_ctrl_t'({
          HWDATA[`BFTF_CTRL_DERATE_LSB +: 8], HWDATA[`BFTF_CTRL_SHUTDOWN_LSB +: 8],
          HWDATA[3:0]});
        default: ;
      endcase
    end
  end

  // Read value sees a write still in its data phase
  always_comb begin
    read_word = 32'h00000000;
    unique case (take_idx)
      `BFTF_IDX_FAULT_TIMING: read_word = {24'h000000, next_fault_timing};
      `BFTF_IDX_TEMP_FILTER: read_word = {24'h000000, next_temp_filter};
      `BFTF_IDX_CAL_DIM: read_word = {24'h000000, next_cal_dim};
      `BFTF_IDX_CONTROL: read_word = {8'h00, next_ctrl.derate_point,
        next_ctrl.shutdown_point, 4'h0, next_ctrl.derate_en, next_ctrl.leading_edge,
        next_ctrl.cal_mode, next_ctrl.full_current};
      `BFTF_IDX_STATUS: read_word = {8'h00, slow_temp, fast_temp, 5'h00,
        ov_state == bftf_pkg::BFTF_OV_RECOVER, BOOST_SHUTDOWN, HEADROOM_FAULT};
      `BFTF_IDX_OUTPUT: read_word = {20'h00000, DIM_LEVEL[11:4], 3'h0, DERATE_ACTIVE};
      default: read_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      req <= '0;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY) begin
        req <= '{idx: take_idx, write: HWRITE, valid: take};
      end
      if (take && !HWRITE) begin
        HRDATA <= read_word;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fault_timing <= `BFTF_RST_FAULT_TIMING;
      temp_filter <= `BFTF_RST_TEMP_FILTER;
      cal_dim <= `BFTF_RST_CAL_DIM;
      ctrl <= bftf_pkg::bftf_ctrl_t'(`BFTF_RST_CONTROL & `BFTF_CTRL_MASK);
    end else begin
      fault_timing <= next_fault_timing;
      temp_filter <= next_temp_filter;
      cal_dim <= next_cal_dim;
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // Half millisecond tick
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      half_ms_cnt <= 20'h00000;
      tick <= 1'b0;
    end else if (half_ms_cnt >= 20'(HALF_MS_CYCLES - 1)) begin
      half_ms_cnt <= 20'h00000;
      tick <= 1'b1;
    end else begin
      half_ms_cnt <= half_ms_cnt + 20'h00001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Line headroom persistence
  // ----------------------------------------------------------------------
  assign headroom_limit = 20'(window_halves(fault_timing[`BFTF_WINDOW_LSB +: 3]) *
    HALF_MS_CYCLES);

  always_ff @(posedge CLK) begin
    if (RST) begin
      headroom_cnt <= 20'h00000;
    end else if (!HEADROOM_LOW) begin
      headroom_cnt <= 20'h00000;
    end else if (headroom_cnt < headroom_limit) begin
      headroom_cnt <= headroom_cnt + 20'h00001;
    end
  end

  // Sticky until software writes one to the status bit; a new trip wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      HEADROOM_FAULT <= 1'b0;
    end else if (HEADROOM_LOW && headroom_cnt >= headroom_limit) begin
      HEADROOM_FAULT <= 1'b1;
    end else if (wr_now && req.idx == `BFTF_IDX_STATUS &&
        HWDATA[`BFTF_STAT_HEADROOM_BIT]) begin
      HEADROOM_FAULT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Boost overvoltage fault handling
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      ov_state <= bftf_pkg::BFTF_RUN;
    end else begin
      unique case (ov_state)
        bftf_pkg::BFTF_RUN: begin
          if (OV_DETECT) begin
            if (fault_timing[`BFTF_RESTART_BIT]) begin
              ov_state <= bftf_pkg::BFTF_OV_RECOVER;
            end else begin
              ov_state <= bftf_pkg::BFTF_OV_LATCHED;
            end
          end
        end
        bftf_pkg::BFTF_OV_RECOVER: begin
          if (BST_AT_NOMINAL && !OV_DETECT) begin
            ov_state <= bftf_pkg::BFTF_RUN;
          end
        end
        bftf_pkg::BFTF_OV_LATCHED: ov_state <= bftf_pkg::BFTF_OV_LATCHED;
        default: ov_state <= bftf_pkg::BFTF_OV_LATCHED;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      BOOST_SHUTDOWN <= 1'b0;
      FULL_CURRENT <= 1'b0;
    end else begin
      BOOST_SHUTDOWN <= (ov_state != bftf_pkg::BFTF_RUN) || OV_DETECT;
      // Full current follows the control bit in every overvoltage state
      FULL_CURRENT <= ctrl.full_current;
    end
  end

  // ----------------------------------------------------------------------
  // Temperature filters
  // ----------------------------------------------------------------------
  assign fast_sel = temp_filter[`BFTF_FAST_LSB +: 3];
  assign slow_sel = temp_filter[`BFTF_SLOW_LSB +: 3];
  assign fast_bypass = (fast_sel == 3'h0) || (fast_sel > 3'h5);
  assign fast_period = fast_table(fast_sel);
  assign slow_period = slow_table(slow_sel);

  bftf_lowpass #(
    .SHIFT(`BFTF_FILT_SHIFT)
  ) u_fast (
    .clk(CLK),
    .rst(RST),
    .tick(tick),
    .sample_valid(TEMP_VALID),
    .sample(TEMP_SAMPLE),
    .bypass(fast_bypass),
    .period(fast_period),
    .filtered(fast_temp)
  );

  bftf_lowpass #(
    .SHIFT(`BFTF_FILT_SHIFT)
  ) u_slow (
    .clk(CLK),
    .rst(RST),
    .tick(tick),
    .sample_valid(TEMP_VALID),
    .sample(TEMP_SAMPLE),
    .bypass(1'b0),
    .period(slow_period),
    .filtered(slow_temp)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      EXT_OVERTEMP <= 1'b0;
      COLOR_TEMP <= 8'h00;
    end else begin
      EXT_OVERTEMP <= fast_temp > ctrl.shutdown_point;
      COLOR_TEMP <= fast_temp;
    end
  end

  // ----------------------------------------------------------------------
  // Dim level selection
  // ----------------------------------------------------------------------
  assign cal_dim_used = (cal_dim == 8'h00) ? `BFTF_CAL_DIM_ZERO_SUB : cal_dim;
  assign cal_dim_level = {cal_dim_used, `BFTF_CAL_DIM_ADD};
  assign derate_amount = {slow_temp - ctrl.derate_point, 4'h0};
  assign derated_dim = (derate_amount >= DIM_REQ) ? 12'h000 : DIM_REQ - derate_amount;

  always_ff @(posedge CLK) begin
    if (RST) begin
      DERATE_ACTIVE <= 1'b0;
      DIM_LEVEL <= 12'h000;
    end else begin
      DERATE_ACTIVE <= ctrl.derate_en && slow_temp > ctrl.derate_point;
      if (ctrl.cal_mode || ctrl.leading_edge) begin
        DIM_LEVEL <= cal_dim_level;
      end else if (ctrl.derate_en && slow_temp > ctrl.derate_point) begin
        DIM_LEVEL <= derated_dim;
      end else begin
        DIM_LEVEL <= DIM_REQ;
      end
    end
  end

endmodule

// file: verification/bftf_top_chk.sv
// Checker of the boost fault, filter and dim block, bound to bftf_top.
// Assumes registers change only through single AHB-Lite word writes.
`timescale 1ns/1ps
`include "bftf_params.svh"
module bftf_top_chk #(
  parameter int HALF_MS_CYCLES = 50000
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HEADROOM_LOW,
  input wire logic OV_DETECT,
  input wire logic BST_AT_NOMINAL,
  input wire logic [11:0] DIM_REQ,
  input wire logic BOOST_SHUTDOWN,
  input wire logic HEADROOM_FAULT,
  input wire logic [11:0] DIM_LEVEL,
  input wire logic FULL_CURRENT
);
  // ----------------------------------------------------------------
  // Register shadow and low-headroom run length
  // ----------------------------------------------------------------
  logic ap_wr;
  logic [7:0] ap_idx;
  logic [7:0] sh_ft;
  logic [7:0] sh_cal;
  logic [3:0] sh_ctl;
  logic [15:0] low_cnt;
  logic cal_on;
  logic [11:0] exp_dim;
  int code;
  int win_n;
  assign cal_on = sh_ctl[1] | sh_ctl[2];
  assign exp_dim = {(sh_cal == 8'h00) ? `BFTF_CAL_DIM_ZERO_SUB : sh_cal, `BFTF_CAL_DIM_ADD};
  assign code = int'(sh_ft[7:5]);
  assign win_n = HALF_MS_CYCLES * ((code < 3) ? 2 * code : ((code == 7) ? 10 : code + 2));
  always_ff @(posedge CLK) begin
    if (RST) begin
      ap_wr <= 1'b0;
      ap_idx <= 8'h00;
    end else if (HREADY) begin
      ap_wr <= HSEL && HTRANS[1] && HWRITE;
      ap_idx <= HADDR[9:2];
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      sh_ft <= 8'h00;
      sh_cal <= 8'h00;
      sh_ctl <= 4'h0;
    end else if (ap_wr) begin
      if (ap_idx == `BFTF_IDX_FAULT_TIMING) sh_ft <= HWDATA[7:0] & `BFTF_FAULT_TIMING_MASK;
      if (ap_idx == `BFTF_IDX_CAL_DIM) sh_cal <= HWDATA[7:0];
      if (ap_idx == `BFTF_IDX_CONTROL) sh_ctl <= HWDATA[3:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (RST || !HEADROOM_LOW) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h0001;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (RST);
  a_ov_shut_next: assert property (OV_DETECT |=> BOOST_SHUTDOWN)
    else $error("overvoltage did not shut boost");
  a_ov_latch_hold: assert property (BOOST_SHUTDOWN && !sh_ft[4] |=> BOOST_SHUTDOWN)
    else $error("latched overvoltage released");
  a_ov_wait_nominal: assert property ((!BST_AT_NOMINAL)[*3] ##0 BOOST_SHUTDOWN |=> BOOST_SHUTDOWN)
    else $error("restart before nominal level");
  a_ov_restart: assert property ((sh_ft[4] && BST_AT_NOMINAL && !OV_DETECT)[*4] |-> !BOOST_SHUTDOWN)
    else $error("no restart at nominal level");
  a_cal_dim_value: assert property ((cal_on && $stable(sh_cal))[*2] |-> DIM_LEVEL == exp_dim)
    else $error("calibration dim level wrong");
  a_dim_pass: assert property ((!RST && !cal_on && !sh_ctl[3])[*2]
    |-> DIM_LEVEL == $past(DIM_REQ))
    else $error("normal dim level not passed");
  a_fault_early: assert property ($rose(HEADROOM_FAULT) |-> int'($past(low_cnt)) >= win_n)
    else $error("headroom fault before window");
  a_fault_late: assert property (int'(low_cnt) > win_n + 1 |-> HEADROOM_FAULT)
    else $error("headroom fault missing after window");
  a_fault_code0: assert property (code == 0 && HEADROOM_LOW |-> ##[1:2] HEADROOM_FAULT)
    else $error("zero window did not trip");
  a_full_cur: assert property ($stable(sh_ctl[0]) |-> FULL_CURRENT == sh_ctl[0])
    else $error("full current not mirrored");
  c_fault: cover property ($rose(HEADROOM_FAULT));
  c_restart: cover property (sh_ft[4] && $fell(BOOST_SHUTDOWN));
  c_cal_zero: cover property (cal_on && sh_cal == 8'h00);
endmodule
bind bftf_top bftf_top_chk #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) u_chk (.CLK(CLK), .RST(RST),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HEADROOM_LOW(HEADROOM_LOW), .OV_DETECT(OV_DETECT),
  .BST_AT_NOMINAL(BST_AT_NOMINAL), .DIM_REQ(DIM_REQ), .BOOST_SHUTDOWN(BOOST_SHUTDOWN),
  .HEADROOM_FAULT(HEADROOM_FAULT), .DIM_LEVEL(DIM_LEVEL), .FULL_CURRENT(FULL_CURRENT));

// file: verification/bftf_top_tb.sv
// Self-checking bench of the boost fault, filter and dim block.
// Assumes the checker file is compiled with it; half a millisecond is 10 cycles here.
`timescale 1ns/1ps
`include "bftf_params.svh"
module bftf_top_tb;
  // ----------------------------------------------------------------
  // Signals, rows and bus tasks
  // ----------------------------------------------------------------
  localparam int HALF = 10;
  typedef struct {
    logic [3:0] ctl;
    logic [7:0] cal;
    logic [11:0] dim;
  } bftf_row_t;
  bftf_row_t rows [5] = '{'{4'h2, 8'h00, 12'h7ff}, '{4'h3, 8'h01, 12'h01f},
    '{4'h4, 8'hff, 12'hfff}, '{4'h5, 8'h80, 12'h80f}, '{4'h1, 8'h80, 12'h345}};
  int hm [8] = '{0, 2, 4, 5, 6, 7, 8, 10};
  logic CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, HEADROOM_LOW, OV_DETECT, BST_AT_NOMINAL;
  logic TEMP_VALID, BOOST_SHUTDOWN, HEADROOM_FAULT, EXT_OVERTEMP, DERATE_ACTIVE, FULL_CURRENT;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, v;
  logic [7:0] TEMP_SAMPLE, COLOR_TEMP;
  logic [11:0] DIM_REQ, DIM_LEVEL;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;
  bftf_top #(.HALF_MS_CYCLES(HALF)) dut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HEADROOM_LOW(HEADROOM_LOW),
    .OV_DETECT(OV_DETECT), .BST_AT_NOMINAL(BST_AT_NOMINAL), .TEMP_VALID(TEMP_VALID),
    .TEMP_SAMPLE(TEMP_SAMPLE), .DIM_REQ(DIM_REQ), .BOOST_SHUTDOWN(BOOST_SHUTDOWN),
    .HEADROOM_FAULT(HEADROOM_FAULT), .EXT_OVERTEMP(EXT_OVERTEMP), .COLOR_TEMP(COLOR_TEMP),
    .DERATE_ACTIVE(DERATE_ACTIVE), .DIM_LEVEL(DIM_LEVEL), .FULL_CURRENT(FULL_CURRENT));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task automatic rdy();
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
  endtask
  // Called just after a rising edge; read data is taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {22'h0, idx, 2'b00};
    rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    rdy();
    v = HRDATA;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic wrd(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
    bus(1'b0, idx, 32'h0);
  endtask
  task automatic pulse(input logic [7:0] s);
    TEMP_SAMPLE <= s;
    TEMP_VALID <= 1'b1;
    @(posedge CLK);
    TEMP_VALID <= 1'b0;
    cyc(9);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {RST, HSEL, HWRITE, HTRANS, HADDR, HWDATA, HSIZE} = {1'b1, 36'h0, 32'h0, 3'h2};
    {HEADROOM_LOW, OV_DETECT, BST_AT_NOMINAL, TEMP_VALID, TEMP_SAMPLE} = 12'h000;
    DIM_REQ = 12'h345;
    cyc(3);
    RST <= 1'b0;
    cyc(1);
    foreach (rows[i]) begin
      wr(`BFTF_IDX_CONTROL, {28'h0, rows[i].ctl});
      wr(`BFTF_IDX_CAL_DIM, {24'h0, rows[i].cal});
      cyc(2);
      chk("dim", DIM_LEVEL, rows[i].dim);
      chk("full", FULL_CURRENT, rows[i].ctl[0]);
    end
    wrd(`BFTF_IDX_FAULT_TIMING, 32'hffffffff);
    chk("ft", v, 32'h000000f0);
    wrd(`BFTF_IDX_CAL_DIM, 32'hffffff5a);
    chk("cal", v, 32'h0000005a);
    wrd(8'h58, 32'h000000ff);
    chk("unmapped", v, 32'h0);
    chk("resp", HRESP, 1'b0);
    for (int c = 0; c < 8; c++) begin
      wrd(`BFTF_IDX_TEMP_FILTER, 32'hc0 | (32'(c) << 3) | 32'(7 - c));
      chk("tf", v, (32'(c) << 3) | 32'(7 - c));
    end
    for (int c = 0; c < 8; c++) begin
      wr(`BFTF_IDX_FAULT_TIMING, 32'(c) << 5);
      HEADROOM_LOW <= 1'b1;
      n = 0;
      do begin
        @(posedge CLK);
        n++;
      end while (HEADROOM_FAULT !== 1'b1 && n < 200);
      chk("window", 32'(n >= HALF * hm[c] + 1 && n <= HALF * hm[c] + 2), 32'h1);
      HEADROOM_LOW <= 1'b0;
      wr(`BFTF_IDX_STATUS, 32'h1);
      cyc(1);
      chk("cleared", HEADROOM_FAULT, 1'b0);
    end
    HEADROOM_LOW <= 1'b1;
    cyc(HALF * 10 - 5);
    HEADROOM_LOW <= 1'b0;
    cyc(1);
    HEADROOM_LOW <= 1'b1;
    cyc(HALF * 10 - 5);
    chk("restarted", HEADROOM_FAULT, 1'b0);
    cyc(10);
    chk("late", HEADROOM_FAULT, 1'b1);
    HEADROOM_LOW <= 1'b0;
    wr(`BFTF_IDX_FAULT_TIMING, 32'h0);
    OV_DETECT <= 1'b1;
    BST_AT_NOMINAL <= 1'b1;
    cyc(1);
    OV_DETECT <= 1'b0;
    cyc(20);
    chk("latched", BOOST_SHUTDOWN, 1'b1);
    bus(1'b0, `BFTF_IDX_STATUS, 32'h0);
    chk("status", v, 32'h00000003);
    RST <= 1'b1;
    DIM_REQ <= 12'h800;
    cyc(3);
    RST <= 1'b0;
    cyc(2);
    chk("unlatched", BOOST_SHUTDOWN, 1'b0);
    wr(`BFTF_IDX_TEMP_FILTER, 32'h08);
    wr(`BFTF_IDX_CONTROL, 32'h00808008);
    pulse(8'h90);
    chk("color", COLOR_TEMP, 8'h90);
    chk("overtemp", EXT_OVERTEMP, 1'b1);
    chk("derate", DERATE_ACTIVE, 1'b1);
    chk("derated", DIM_LEVEL, 12'h700);
    repeat (4) pulse(8'h10);
    chk("fast slow", 32'(COLOR_TEMP >= 8'h88), 32'h1);
    repeat (60) pulse(8'h10);
    chk("fast moves", 32'(COLOR_TEMP > 8'h10 && COLOR_TEMP <= 8'h88), 32'h1);
    chk("slow holds", DERATE_ACTIVE, 1'b1);
    wr(`BFTF_IDX_TEMP_FILTER, 32'h0);
    pulse(8'h10);
    chk("bypass", COLOR_TEMP, 8'h10);
    chk("cool", EXT_OVERTEMP, 1'b0);
    wr(`BFTF_IDX_FAULT_TIMING, 32'h10);
    BST_AT_NOMINAL <= 1'b0;
    OV_DETECT <= 1'b1;
    cyc(1);
    OV_DETECT <= 1'b0;
    cyc(20);
    chk("waits", BOOST_SHUTDOWN, 1'b1);
    BST_AT_NOMINAL <= 1'b1;
    cyc(5);
    chk("restart", BOOST_SHUTDOWN, 1'b0);
    tally_and_finish();
  end
endmodule
